// ==== charger_status_pkg.sv ====
// ****************************************************************
// charger status constants
// ****************************************************************
package charger_status_pkg;

  // bus side: 7-bit slave address and read-word command codes
  localparam logic [6:0]  SLAVE_ADDR     = 7'h09;
  localparam logic [7:0]  CAPABILITY_CMD = 8'h11;
  localparam logic [7:0]  STATUS_CMD     = 8'h13;
  localparam logic [3:0]  LAST_BIT       = 4'h7;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;

  // status word bit positions
  localparam int B_INHIBIT = 0;
  localparam int B_POLL    = 1;
  localparam int B_VNREG   = 2;
  localparam int B_ANREG   = 3;
  localparam int B_LEVEL2  = 4;
  localparam int B_LEVEL3  = 5;
  localparam int B_AMP_OR  = 6;
  localparam int B_VOLT_OR = 7;
  localparam int B_SAFE_LO = 8;
  localparam int B_ALARM   = 12;
  localparam int B_PFAIL   = 13;
  localparam int B_BATT    = 14;
  localparam int B_SUPPLY  = 15;

  // reset value: the always-one level bit and the level3 capability
  // bit, so the level bits read right from the first edge after reset
  localparam logic [15:0] STATUS_RESET = {10'h000, LEVEL3_CAP, 5'h10};

  // charger capability
  localparam logic        LEVEL3_CAP   = 1'b1;
  localparam logic [3:0]  SPEC_REV     = 4'h2;
  localparam logic        SELECTOR_SUP = 1'b0;
  localparam logic [15:0] CAPABILITY_WORD =
    {11'h000, SELECTOR_SUP, SPEC_REV};

  // programmed value regulation limits (mA, mV)
  localparam logic [15:0] MAX_AMP  = 16'h1F40;
  localparam logic [15:0] MAX_VOLT = 16'h4650;

  // safety resistor limits in ohms: open, cold, hot, low
  localparam int          SAFETY_FLAGS = 4;
  localparam int          OPEN_IDX     = 0;
  localparam logic [16:0] SAFETY_LIMIT [SAFETY_FLAGS] =
    '{17'h17318, 17'h06F54, 17'h00C4E, 17'h0023F};
  // one where the flag is set above the limit, zero where below
  localparam logic [3:0]  SAFETY_ABOVE = 4'h3;

  // read-word engine states
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK,
    S_WAIT_RS, S_TX, S_MACK, S_DONE
  } smb_state_t;

endpackage : charger_status_pkg

// ==== charger_status_regs.sv ====
`timescale 1ns/1ps
// Contract
// - status bit 0 mirrors charge inhibit
// - bit 1 set when level3 and polling
// - bit 2 flags voltage not regulated
// - bit 3 flags current not regulated
// - bit 4 always one, bit 5 level3
// - level3 acts level2 when polling off
// - bit 6 current outside regulation range
// - bit 7 voltage outside regulation range
// - bit 8 safety above 95 kilohm
// - bit 9 safety above 28500 ohm
// - bit 10 safety below 3150 ohm
// - bit 11 below 575, flags independent
// - bit 12 set on alarm inhibit
// - bit 12 cleared by rewrite or removal
// - bit 13 follows power fail comparator
// - bit 14 battery present, inverse open
// - bit 15 charging power available
// - capability word at command 0x11
// - capability bits 3..0 give revision
// - capability bit 4 selector support
// - capability upper bits read zero
// - status word at command 0x13
// - inhibit cleared on power up, reinsertion
module charger_status_regs (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_oe,
  output logic             o_sda_out,
  input  wire logic        i_mode_wr,
  input  wire logic        i_mode_inhibit,
  input  wire logic        i_mode_polling,
  input  wire logic        i_charger_enabled,
  input  wire logic        i_volt_unregulated,
  input  wire logic        i_amp_unregulated,
  input  wire logic [15:0] i_target_amp_value,
  input  wire logic [15:0] i_target_volt_value,
  input  wire logic        i_volt_written,
  input  wire logic        i_amp_written,
  input  wire logic        i_warning_message,
  input  wire logic [16:0] i_safety_ohms,
  input  wire logic        i_power_fail_cmp,
  input  wire logic        i_supply_available,
  output logic [15:0]      o_status_word
);
  import charger_status_pkg::*;

  // ****************************************************************
  // line watch and safety decode
  // ****************************************************************
  smb_line_if line ();        // decoded bus events
  logic [3:0] safety_flags;   // open, cold, hot, low
  logic       batt_present;   // battery seen on the safety line

  smb_line_watch u_watch (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_scl  (i_scl),
    .i_sda  (i_sda),
    .line   (line)
  );

  safety_range_decode u_safety (
    .i_ohms  (i_safety_ohms),
    .o_flags (safety_flags)
  );

  assign batt_present = ~safety_flags[OPEN_IDX];

  // ****************************************************************
  // mode, alarm and status state
  // ****************************************************************
  logic        inhibit_q, inhibit_d;   // charge inhibit mode
  logic        polling_q, polling_d;   // polling enable mode
  logic        alarm_q, alarm_d;       // alarm inhibit flag
  logic        vrw_q, vrw_d;           // voltage rewritten since alarm
  logic        arw_q, arw_d;           // current rewritten since alarm
  logic        batt_q, batt_d;         // battery present last cycle
  logic [15:0] status_q, status_d;     // sampled status word
  logic        alarm_clr;              // any alarm clear cause

  // next values of the mode and status state
  always_comb begin
    inhibit_d = inhibit_q;
    polling_d = polling_q;
    batt_d    = batt_present;
    if (batt_present && !batt_q) begin
      inhibit_d = 1'b0;
    end
    // mode write wins over the reinsertion clear
    if (i_mode_wr) begin
      inhibit_d = i_mode_inhibit;
      // polling held off on level2 parts
      polling_d = i_mode_polling & LEVEL3_CAP;
    end
    alarm_clr = ((vrw_q | i_volt_written) & (arw_q | i_amp_written))
              | ~i_supply_available | ~batt_present;
    vrw_d = vrw_q | i_volt_written;
    arw_d = arw_q | i_amp_written;
    // warning sets, and wins over a clear
    if (i_warning_message) begin
      alarm_d = 1'b1;
      vrw_d   = 1'b0;
      arw_d   = 1'b0;
    end else if (alarm_clr) begin
      alarm_d = 1'b0;
      vrw_d   = 1'b0;
      arw_d   = 1'b0;
    end else begin
      alarm_d = alarm_q;
    end
    status_d = '0;
    status_d[B_INHIBIT] = inhibit_q;
    status_d[B_POLL] = LEVEL3_CAP & polling_q;
    status_d[B_VNREG] = i_charger_enabled & i_volt_unregulated;
    status_d[B_ANREG] = i_charger_enabled & i_amp_unregulated;
    status_d[B_LEVEL2] = 1'b1;
    status_d[B_LEVEL3] = LEVEL3_CAP;
    status_d[B_AMP_OR] = (i_target_amp_value > MAX_AMP);
    status_d[B_VOLT_OR] = (i_target_volt_value > MAX_VOLT);
    status_d[B_SAFE_LO +: SAFETY_FLAGS] = safety_flags;
    status_d[B_ALARM] = alarm_q;
    status_d[B_PFAIL] = i_power_fail_cmp;
    status_d[B_BATT] = batt_present;
    status_d[B_SUPPLY] = i_supply_available;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      inhibit_q <= 1'b0;
      polling_q <= LEVEL3_CAP;
      alarm_q   <= 1'b0;
      vrw_q     <= 1'b0;
      arw_q     <= 1'b0;
      batt_q    <= 1'b0;
      status_q  <= STATUS_RESET;
    end else begin
      inhibit_q <= inhibit_d;
      polling_q <= polling_d;
      alarm_q   <= alarm_d;
      vrw_q     <= vrw_d;
      arw_q     <= arw_d;
      batt_q    <= batt_d;
      status_q  <= status_d;
    end
  end

  assign o_status_word = status_q;

  // ****************************************************************
  // read-word engine
  // ****************************************************************
  smb_state_t  state_q, state_d;   // transaction phase
  logic [3:0]  cnt_q, cnt_d;       // bit count within a byte
  logic [7:0]  shift_q, shift_d;   // received bits
  logic [15:0] tx_q, tx_d;         // outgoing bits, msb next
  logic        oe_q, oe_d;         // pull data line low
  logic        ack_q, ack_d;       // acknowledge slot in progress
  logic        read_q, read_d;     // address phase was a read
  logic        cmd_ok_q, cmd_ok_d; // supported command held
  logic        cmd_st_q, cmd_st_d; // held command is status word
  logic        byte1_q, byte1_d;   // second data byte under way
  logic        more_q, more_d;     // master asked for next byte
  logic [7:0]  rx_byte;            // byte finishing on this rise
  logic [15:0] snap;               // word chosen for the read

  assign rx_byte = {shift_q[6:0], line.sda};
  assign snap = cmd_st_q ? status_q : CAPABILITY_WORD;

  // next values of the engine
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    shift_d  = shift_q;
    tx_d     = tx_q;
    oe_d     = oe_q;
    ack_d    = ack_q;
    read_d   = read_q;
    cmd_ok_d = cmd_ok_q;
    cmd_st_d = cmd_st_q;
    byte1_d  = byte1_q;
    more_d   = more_q;
    case (state_q)
      // address byte, sampled on rising clock
      S_ADDR: begin
        if (line.scl_rise) begin
          shift_d = rx_byte;
          cnt_d   = cnt_q + 4'h1;
          if (cnt_q == LAST_BIT) begin
            cnt_d  = '0;
            read_d = line.sda;
            if (shift_q[6:0] == SLAVE_ADDR &&
                (!line.sda || cmd_ok_q)) begin
              state_d = S_ADDR_ACK;
            end else begin
              state_d = S_IDLE;
            end
          end
        end
      end
      // address acknowledge, then command or data
      S_ADDR_ACK: begin
        if (line.scl_fall) begin
          if (!ack_q) begin
            oe_d  = 1'b1;
            ack_d = 1'b1;
          end else if (read_q) begin
            ack_d   = 1'b0;
            tx_d    = {snap[6:0], snap[15:8], 1'b0};
            oe_d    = ~snap[7];
            cnt_d   = '0;
            state_d = S_TX;
          end else begin
            ack_d   = 1'b0;
            oe_d    = 1'b0;
            cnt_d   = '0;
            state_d = S_CMD;
          end
        end
      end
      // command byte
      S_CMD: begin
        if (line.scl_rise) begin
          shift_d = rx_byte;
          cnt_d   = cnt_q + 4'h1;
          if (cnt_q == LAST_BIT) begin
            cnt_d = '0;
            if (rx_byte == STATUS_CMD || rx_byte == CAPABILITY_CMD) begin
              cmd_ok_d = 1'b1;
              cmd_st_d = (rx_byte == STATUS_CMD);
              state_d  = S_CMD_ACK;
            end else begin
              cmd_ok_d = 1'b0;
              state_d  = S_IDLE;
            end
          end
        end
      end
      // command acknowledge
      S_CMD_ACK: begin
        if (line.scl_fall) begin
          if (!ack_q) begin
            oe_d  = 1'b1;
            ack_d = 1'b1;
          end else begin
            oe_d    = 1'b0;
            ack_d   = 1'b0;
            state_d = S_WAIT_RS;
          end
        end
      end
      // data bits, low byte first, changed on falling clock
      S_TX: begin
        if (line.scl_rise) begin
          cnt_d = cnt_q + 4'h1;
        end else if (line.scl_fall) begin
          if (cnt_q == BYTE_BITS) begin
            oe_d    = 1'b0;
            cnt_d   = '0;
            state_d = S_MACK;
          end else begin
            oe_d = ~tx_q[15];
            tx_d = {tx_q[14:0], 1'b0};
          end
        end
      end
      // master acknowledge after each data byte
      S_MACK: begin
        if (line.scl_rise) begin
          if (!line.sda && !byte1_q) begin
            more_d  = 1'b1;
            byte1_d = 1'b1;
          end else begin
            state_d = S_DONE;
          end
        end else if (line.scl_fall && more_q) begin
          more_d  = 1'b0;
          oe_d    = ~tx_q[15];
          tx_d    = {tx_q[14:0], 1'b0};
          cnt_d   = '0;
          state_d = S_TX;
        end
      end
      // idle, waiting for a repeated start or finished
      default: begin
        state_d = state_q;
      end
    endcase
    // stop ends everything, start reopens the address phase
    if (line.stop) begin
      state_d  = S_IDLE;
      oe_d     = 1'b0;
      ack_d    = 1'b0;
      cmd_ok_d = 1'b0;
    end else if (line.start) begin
      state_d = S_ADDR;
      cnt_d   = '0;
      oe_d    = 1'b0;
      ack_d   = 1'b0;
      byte1_d = 1'b0;
      more_d  = 1'b0;
    end
  end

  // engine registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q  <= S_IDLE;
      cnt_q    <= '0;
      shift_q  <= '0;
      tx_q     <= '0;
      oe_q     <= 1'b0;
      ack_q    <= 1'b0;
      read_q   <= 1'b0;
      cmd_ok_q <= 1'b0;
      cmd_st_q <= 1'b0;
      byte1_q  <= 1'b0;
      more_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      shift_q  <= shift_d;
      tx_q     <= tx_d;
      oe_q     <= oe_d;
      ack_q    <= ack_d;
      read_q   <= read_d;
      cmd_ok_q <= cmd_ok_d;
      cmd_st_q <= cmd_st_d;
      byte1_q  <= byte1_d;
      more_q   <= more_d;
    end
  end

  // open-drain data: only ever pulls low
  assign o_sda_oe  = oe_q;
  assign o_sda_out = 1'b0;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_inhibit_write;
    i_mode_wr && i_mode_inhibit;
  endsequence

  sequence s_warning;
    i_warning_message ##1 alarm_q;
  endsequence

  a_inhibit_mirror: assert property (
    s_inhibit_write |=> inhibit_q ##1 status_q[B_INHIBIT])
    else $error("inhibit mode not shown in status");
  a_poll_level: assert property (
    status_q[B_POLL] |-> $past(polling_q) && LEVEL3_CAP)
    else $error("polling bit without level3 polling");
  a_level_bits: assert property (
    status_q[B_LEVEL2] && status_q[B_LEVEL3] == LEVEL3_CAP)
    else $error("level bits wrong");
  a_amp_range: assert property (
    (i_target_amp_value == MAX_AMP + 16'h0001) |=> status_q[B_AMP_OR])
    else $error("current one above maximum not flagged");
  a_open_battery: assert property (
    (i_safety_ohms > SAFETY_LIMIT[OPEN_IDX]) |=>
      status_q[B_SAFE_LO] && !status_q[B_BATT])
    else $error("open safety line not decoded");
  a_alarm_set: assert property (
    s_warning |=> status_q[B_ALARM])
    else $error("alarm inhibit not reported");
  a_alarm_clear: assert property (
    (!i_warning_message && !i_supply_available) |=> !alarm_q ##1
      !status_q[B_ALARM])
    else $error("alarm inhibit kept after power loss");
  a_idle_release: assert property (
    (state_q == S_IDLE) |-> !o_sda_oe)
    else $error("data line driven while idle");
  a_stop_idle: assert property (
    line.stop |=> state_q == S_IDLE && !cmd_ok_q)
    else $error("stop did not end transaction");
endmodule : charger_status_regs

// ==== safety_range_decode.sv ====
`timescale 1ns/1ps
// ****************************************************************
// safety resistor range flags
// ****************************************************************
module safety_range_decode (
  input  wire logic [16:0]                            i_ohms,
  output logic [charger_status_pkg::SAFETY_FLAGS-1:0] o_flags
);
  import charger_status_pkg::*;

  // each flag compares on its own, so several may be set at once
  for (genvar g = 0; g < SAFETY_FLAGS; g++) begin : g_flag
    if (SAFETY_ABOVE[g]) begin : g_above
      assign o_flags[g] = (i_ohms > SAFETY_LIMIT[g]);
    end else begin : g_below
      assign o_flags[g] = (i_ohms < SAFETY_LIMIT[g]);
    end
  end
endmodule : safety_range_decode

// ==== smb_host_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// bus host model: read word transfers over open-drain lines
// ****************************************************************
module smb_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  logic seen;  // data level sampled mid high phase
  logic busy;  // inside a frame, clock held low between bits

  // both lines released while idle, clock stands still
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    busy     = 1'b0;
  end

  // wait a number of clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  // one clock pulse: data changes only while the clock is low
  task automatic bit_cycle(input logic drv_low);
    tick(3);
    o_sda_oe <= drv_low;
    tick(3);
    o_scl_oe <= 1'b0;
    tick(3);
    seen = i_sda;
    tick(3);
    o_scl_oe <= 1'b1;
  endtask : bit_cycle

  // start, or repeated start from inside a frame
  task automatic start_cond();
    if (busy) begin
      tick(3);
      o_sda_oe <= 1'b0;
      tick(3);
      o_scl_oe <= 1'b0;
      tick(6);
    end
    o_sda_oe <= 1'b1;
    tick(6);
    o_scl_oe <= 1'b1;
    busy = 1'b1;
  endtask : start_cond

  // stop: data rises while the clock is high
  task automatic stop_cond();
    tick(3);
    o_sda_oe <= 1'b1;
    tick(3);
    o_scl_oe <= 1'b0;
    tick(6);
    o_sda_oe <= 1'b0;
    tick(6);
    busy = 1'b0;
  endtask : stop_cond

  // eight bits msb first, then the ninth clock samples the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_cycle(~b[i]);
    bit_cycle(1'b0);
    ack = ~seen;
  endtask : send_byte

  // full read word; any missing ack ends the frame with a stop
  task automatic read_word(input logic [6:0] addr, input logic [7:0] cmd,
    input logic skip_cmd, output logic [15:0] data,
    output logic [2:0] acks);
    logic a;
    acks = 3'h0;
    data = 16'h0000;
    start_cond();
    if (!skip_cmd) begin
      send_byte({addr, 1'b0}, a);
      acks[0] = a;
      if (a) send_byte(cmd, a);
      acks[1] = a;
      if (!a) begin
        stop_cond();
        return;
      end
      start_cond();
    end
    send_byte({addr, 1'b1}, a);
    acks[2] = a;
    // low byte first, master ack after it, nack after high byte
    if (a) for (int i = 0; i < 16; i++) begin
      bit_cycle(1'b0);
      data[(i < 8) ? 7 - i : 23 - i] = seen;
      if (i == 7) bit_cycle(1'b1);
      if (i == 15) bit_cycle(1'b0);
    end
    stop_cond();
  endtask : read_word
endmodule : smb_host_model

// ==== smb_line_if.sv ====
`timescale 1ns/1ps
// ****************************************************************
// decoded bus line events
// ****************************************************************
interface smb_line_if;
  logic scl_rise;  // clock line went high
  logic scl_fall;  // clock line went low
  logic start;     // data fell while clock high
  logic stop;      // data rose while clock high
  logic sda;       // current data line level

  modport watch  (output scl_rise, scl_fall, start, stop, sda);
  modport engine (input  scl_rise, scl_fall, start, stop, sda);
endinterface : smb_line_if

// ==== smb_line_watch.sv ====
`timescale 1ns/1ps
// ****************************************************************
// bus line edge and condition detector
// ****************************************************************
module smb_line_watch (
  input  wire logic    i_clk,
  input  wire logic    i_nrst,
  input  wire logic    i_scl,
  input  wire logic    i_sda,
  smb_line_if.watch    line
);
  logic scl_q, scl_d;  // previous clock level
  logic sda_q, sda_d;  // previous data level

  // next values are the current line levels
  always_comb begin
    scl_d = i_scl;
    sda_d = i_sda;
  end

  // idle bus reads high on both lines
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // edges and start or stop conditions
  assign line.scl_rise = i_scl & ~scl_q;
  assign line.scl_fall = ~i_scl & scl_q;
  assign line.start    = i_scl & scl_q & sda_q & ~i_sda;
  assign line.stop     = i_scl & scl_q & ~sda_q & i_sda;
  assign line.sda      = i_sda;
endmodule : smb_line_watch

// ==== tb_top.sv ====
`timescale 1ns/1ps
// ****************************************************************
// status word bench
// ****************************************************************
module tb_top;
  import charger_status_pkg::*;
  logic        i_clk, i_nrst, i_mode_wr, i_mode_inhibit, i_mode_polling;
  logic        i_charger_enabled, i_volt_unregulated, i_amp_unregulated;
  logic        i_volt_written, i_amp_written, i_warning_message;
  logic        i_power_fail_cmp, i_supply_available;
  logic [15:0] i_target_amp_value, i_target_volt_value, o_status_word;
  logic [16:0] i_safety_ohms;
  logic        scl, sda, dut_oe, dut_out, host_scl_oe, host_sda_oe;
  logic        inh_m, poll_m, alarm_m;  // expected mode and alarm state
  logic [15:0] rd;                      // word read over the bus
  logic [2:0]  acks;                    // acks seen by the host
  int          err_count, checks, cycles;

  // open-drain wires with pull-ups
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dut_oe);

  charger_status_regs charger_status_regs_inst (
    .i_clk, .i_nrst, .i_scl(scl), .i_sda(sda), .o_sda_oe(dut_oe),
    .o_sda_out(dut_out), .i_mode_wr, .i_mode_inhibit, .i_mode_polling,
    .i_charger_enabled, .i_volt_unregulated, .i_amp_unregulated,
    .i_target_amp_value, .i_target_volt_value, .i_volt_written,
    .i_amp_written, .i_warning_message, .i_safety_ohms,
    .i_power_fail_cmp, .i_supply_available, .o_status_word);

  smb_host_model smb_host_model_inst (.i_clk, .i_sda(sda),
    .o_scl_oe(host_scl_oe), .o_sda_oe(host_sda_oe));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // status word worked out from the bench's own view of the inputs
  function automatic logic [15:0] expect_status();
    logic [15:0] e;
    e[0] = inh_m;
    e[1] = LEVEL3_CAP & poll_m;
    e[2] = i_charger_enabled & i_volt_unregulated;
    e[3] = i_charger_enabled & i_amp_unregulated;
    e[4] = 1'b1;
    e[5] = LEVEL3_CAP;
    e[6] = i_target_amp_value > MAX_AMP;
    e[7] = i_target_volt_value > MAX_VOLT;
    e[8] = i_safety_ohms > 17'h17318;   // 95000
    e[9] = i_safety_ohms > 17'h06F54;   // 28500
    e[10] = i_safety_ohms < 17'h00C4E;  // 3150
    e[11] = i_safety_ohms < 17'h0023F;  // 575
    e[12] = alarm_m;
    e[13] = i_power_fail_cmp;
    e[14] = i_safety_ohms <= 17'h17318;
    e[15] = i_supply_available;
    return e;
  endfunction : expect_status

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // let input changes reach the status register
  task automatic look();
    repeat (3) @(posedge i_clk);
  endtask : look

  task automatic mode_write(input logic inh, input logic poll);
    @(posedge i_clk);
    i_mode_wr <= 1'b1;
    i_mode_inhibit <= inh;
    i_mode_polling <= poll;
    @(posedge i_clk);
    i_mode_wr <= 1'b0;
    inh_m = inh;
    poll_m = poll;
  endtask : mode_write

  // one-cycle pulse: 0 warning, 1 voltage written, 2 current written
  task automatic strobe(input int which);
    @(posedge i_clk);
    i_warning_message <= (which == 0);
    i_volt_written <= (which == 1);
    i_amp_written <= (which == 2);
    @(posedge i_clk);
    {i_warning_message, i_volt_written, i_amp_written} <= 3'h0;
  endtask : strobe

  task automatic t_mode();
    for (int i = 0; i < 4; i++) begin
      mode_write(i[0], i[1]);
      look();
      check(o_status_word, expect_status());
    end
  endtask : t_mode

  task automatic t_regulation();
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      {i_charger_enabled, i_volt_unregulated, i_amp_unregulated} <= i[2:0];
      look();
      check(o_status_word, expect_status());
    end
    i_charger_enabled <= 1'b1;
  endtask : t_regulation

  task automatic t_range();
    logic [15:0] tab [3];
    tab = '{16'h0000, 16'h0001, 16'h8000};
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      i_target_amp_value <= MAX_AMP + tab[i];
      i_target_volt_value <= MAX_VOLT + tab[2 - i];
      look();
      check(o_status_word, expect_status());
    end
  endtask : t_range

  task automatic t_safety();
    logic [16:0] tab [10];
    logic        gone;  // battery seen absent since last insertion
    tab = '{17'h17319, 17'h17318, 17'h06F55, 17'h06F54, 17'h00C4E,
            17'h00C4D, 17'h0023F, 17'h0023E, 17'h00190, 17'h1FFFF};
    gone = 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      i_safety_ohms <= tab[i];
      if (tab[i] > 17'h17318) begin
        gone = 1'b1;
      end else if (gone) begin
        inh_m = 1'b0;
        gone  = 1'b0;
      end
      look();
      check(o_status_word, expect_status());
    end
    i_safety_ohms <= 17'h02710;
  endtask : t_safety

  task automatic t_alarm();
    strobe(0);
    alarm_m = 1'b1;
    look();
    check(o_status_word, expect_status());
    strobe(2);
    look();
    check(o_status_word, expect_status());
    strobe(1);
    alarm_m = 1'b0;
    look();
    check(o_status_word, expect_status());
    strobe(0);
    i_supply_available <= 1'b0;
    i_power_fail_cmp <= 1'b1;
    look();
    check(o_status_word, expect_status());
    i_supply_available <= 1'b1;
    mode_write(1'b1, 1'b1);
    strobe(0);
    alarm_m = 1'b1;
    i_safety_ohms <= 17'h1FFFF;
    alarm_m = 1'b0;
    look();
    check(o_status_word, expect_status());
    i_safety_ohms <= 17'h02710;
    inh_m = 1'b0;
    look();
    check(o_status_word, expect_status());
  endtask : t_alarm

  task automatic t_bus();
    smb_host_model_inst.read_word(SLAVE_ADDR, 8'h13, 1'b0, rd, acks);
    check(acks, 3'h7);
    check(rd, expect_status());
    check(dut_out, 1'b0);
    smb_host_model_inst.read_word(SLAVE_ADDR, 8'h11, 1'b0, rd, acks);
    check(rd, {11'h000, SELECTOR_SUP, SPEC_REV});
    check(SPEC_REV inside {4'h1, 4'h2, 4'h3}, 1'b1);
    smb_host_model_inst.read_word(7'h0A, 8'h13, 1'b0, rd, acks);
    check(acks, 3'h0);
    smb_host_model_inst.read_word(SLAVE_ADDR, 8'h12, 1'b0, rd, acks);
    check(acks, 3'h1);
    smb_host_model_inst.read_word(SLAVE_ADDR, 8'h13, 1'b1, rd, acks);
    check(acks, 3'h0);
  endtask : t_bus

  // second reset in mid-run restores power-up modes
  task automatic t_reset();
    mode_write(1'b1, 1'b0);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    look();
    check(o_status_word, STATUS_RESET);
    check(dut_oe, 1'b0);
    i_nrst <= 1'b1;
    inh_m = 1'b0;
    poll_m = 1'b1;
    look();
    check(o_status_word, expect_status());
  endtask : t_reset

  // hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  // main sequence
  initial begin
    {i_nrst, i_mode_wr, i_mode_inhibit, i_mode_polling} <= 4'h0;
    {i_volt_unregulated, i_amp_unregulated, i_power_fail_cmp} <= 3'h0;
    {i_volt_written, i_amp_written, i_warning_message} <= 3'h0;
    {i_charger_enabled, i_supply_available} <= 2'h3;
    i_target_amp_value <= 16'h0BB8;
    i_target_volt_value <= 16'h3E80;
    i_safety_ohms <= 17'h02710;
    {inh_m, poll_m, alarm_m} = 3'h2;
    repeat (4) @(posedge i_clk);
    check(o_status_word, STATUS_RESET);
    i_nrst <= 1'b1;
    look();
    check(o_status_word, expect_status());
    t_mode();
    t_regulation();
    t_range();
    t_safety();
    t_alarm();
    t_bus();
    t_reset();
    test_done();
  end
endmodule : tb_top
